// ==== verilog/smsp_regs.vh ====
// Purpose: Register map, field positions and reset values of the serial port
// Assumes: Byte address of a register is four times its index
// Notes:   Included by smsp_core.v only
//
// Overview of operation
// - Set done flag when any byte completes
// - Busy data write sets collision, byte dropped
// - Master sees select input low: mode fault
// - Fault clears master and enable, flags, interrupts
// - Status read then data access clears done/collision
// - Status read with fault, control write clears
// - Auto select drives pattern per byte only as master
// - Auto select off: outputs always equal pattern
// - Bytes leave most significant bit first
// - Data read gives last received byte
// - Master write starts, shifts at timer overflow
// - Master makes clock and enables its driver
// - Eight separate select outputs address slaves
// - Slave shifts when master selects and clocks
// - Slave flags done after eight bits
// - Slave reports collisions only, never faults
// - Slave phase zero: write with select low collides
// - Unselected slave leaves shared lines alone
// - One bit out and in per clock
// - Master clock is system clock over 4..512
// - Clock idles at the polarity bit level
// - Select high aborts slave, clears bit count
// - Master done at end of eighth clock
`ifndef SMSP_REGS_VH
`define SMSP_REGS_VH

// Register indices and bus offsets
`define SMSP_IDX_CTRL   12'h0ec
`define SMSP_IDX_STAT   12'h0ed
`define SMSP_IDX_DATA   12'h0ee
`define SMSP_IDX_SEL    12'h0ef
`define SMSP_ADDR_W     12

// Control register fields
`define SMSP_C_IE       7
`define SMSP_C_EN       6
`define SMSP_C_RATE2    5
`define SMSP_C_MASTER_SELECT_BIT     4
`define SMSP_C_CLOCK_POLARITY_BIT     3
`define SMSP_C_CLOCK_PHASE_BIT     2
`define SMSP_C_RATE1    1
`define SMSP_C_RATE0    0

// Status register fields
`define SMSP_S_DONE     7
`define SMSP_S_WRITE_COLLISION_FLAG     6
`define SMSP_S_MODE_FAULT_FLAG     4
`define SMSP_S_FIXED    2
`define SMSP_S_AUTO     0

// Reset values
`define SMSP_CTRL_RST   8'h04
`define SMSP_STAT_RST   8'h04
`define SMSP_DATA_RST   8'h04
`define SMSP_SEL_RST    8'hff

// Transfer geometry
`define SMSP_BITS       4'h8
`define SMSP_EDGES      5'h10
`define SMSP_HALF_MIN   10'h002

`endif

// ==== verilog/smsp_core.v ====
// Purpose: Full-duplex serial port, master or slave, behind an AHB-Lite slave
// Assumes: Single clock ref_clk; serial pins are synchronised before use
// Notes:   Zero-wait bus; read data is captured in the address phase
//
// Added by the designer: register access over AHB-Lite.
`default_nettype none
`include "smsp_regs.vh"

module smsp_core (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        sys_rst,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	// Serial clock pin
	input  wire        sckIn,
	output wire        sckOut,
	output wire        sckOe,
	// Master-out data pin
	input  wire        mosiIn,
	output wire        mosiOut,
	output wire        mosiOe,
	// Master-in data pin
	input  wire        misoIn,
	output wire        misoOut,
	output wire        misoOe,
	// Slave select
	input  wire        ssInN,
	output reg  [7:0]  ssOutN,
	// Interrupt request
	output wire        irq
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	// Master sequencer states, one-hot
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_WAIT = 3'b010;
	localparam [2:0] ST_RUN  = 3'b100;

	reg  [7:0]  ctrl_q;      // Control register
	reg  [7:0]  sel_q;       // Select pattern register
	reg         auto_q;      // Auto select enable
	reg         done_q;      // Transfer done flag
	reg         write_collision_flag_q;      // Write collision flag
	reg         mode_fault_flag_q;      // Mode fault flag
	reg         armDc_q;     // Status read seen, data access may clear
	reg         armMf_q;     // Status read with fault seen
	reg  [7:0]  shift_q;     // Shared transmit/receive shifter
	reg  [7:0]  rxBuf_q;     // Receive buffer
	reg         outBit_q;    // Bit currently driven out
	reg  [2:0]  state_q;     // Master sequencer
	reg  [4:0]  edgeCnt_q;   // Master clock edges done
	reg         sckLvl_q;    // Master clock level
	reg  [9:0]  baud_q;      // Bit-rate timer
	reg  [3:0]  slvCnt_q;    // Slave bits sampled
	reg         slvAct_q;    // Slave transfer under way
	reg         aWr_q;       // Pending write data phase
	reg  [11:0] aIdx_q;      // Index of pending write
	reg         ss1_q;       // Select input sync stage 1
	reg         ss2_q;       // Select input sync stage 2
	reg         sck1_q;      // Clock input sync stage 1
	reg         sck2_q;      // Clock input sync stage 2
	reg         sckPrev_q;   // Previous synced clock
	reg         mosi1_q;     // Slave data in sync stage 1
	reg         mosi2_q;     // Slave data in sync stage 2
	reg         miso1_q;     // Master data in sync stage 1
	reg         miso2_q;     // Master data in sync stage 2
	reg         ssPrev_q;    // Previous synced select

	wire        enBit   = ctrl_q[`SMSP_C_EN];
	wire        mstrBit = ctrl_q[`SMSP_C_MASTER_SELECT_BIT];
	wire        clock_polarity_bit    = ctrl_q[`SMSP_C_CLOCK_POLARITY_BIT];
	wire        clock_phase_bit    = ctrl_q[`SMSP_C_CLOCK_PHASE_BIT];
	wire [2:0]  rate    = {ctrl_q[`SMSP_C_RATE2], ctrl_q[`SMSP_C_RATE1:`SMSP_C_RATE0]};
	wire        isMst   = enBit & mstrBit;
	wire        slvSel  = enBit & ~mstrBit & ~ss2_q;
	wire [9:0]  halfPer = `SMSP_HALF_MIN << rate;                // Half of 4 << rate
	wire        baudTick = (baud_q >= halfPer - 10'h001);       // Count left from a slower rate overflows at once
	wire        fault   = mstrBit & ~ss2_q;
	wire        mRun    = (state_q == ST_RUN);
	wire        mBusy   = (state_q != ST_IDLE);

	// Slave clock edges; leading leaves the idle level
	wire        sEdge   = slvSel & (sck2_q != sckPrev_q);
	wire        sLead   = sEdge & (sck2_q != clock_polarity_bit);
	wire        sSample = sEdge & (sLead ^ clock_phase_bit);
	wire        sShiftO = sEdge & ~(sLead ^ clock_phase_bit);
	// Phase zero: whole select-low window counts as busy
	wire        sBusy   = slvAct_q | (slvSel & ~clock_phase_bit);
	wire        sDone   = sSample & (slvCnt_q == `SMSP_BITS - 4'h1);

	// Master edges, one per timer overflow while running
	wire        mEdge   = mRun & baudTick;
	wire        mLead   = mEdge & ~edgeCnt_q[0];
	wire        mSample = mEdge & (mLead ^ clock_phase_bit);
	wire        mShiftO = mEdge & ~(mLead ^ clock_phase_bit);
	wire        mDone   = mEdge & (edgeCnt_q == `SMSP_EDGES - 5'h01);

	// Bus decode
	wire        aValid  = hsel & hready & htrans[1];
	wire [11:0] aIdx    = haddr[`SMSP_ADDR_W+1:2];
	wire        rdStat  = aValid & ~hwrite & (aIdx == `SMSP_IDX_STAT);
	wire        rdData  = aValid & ~hwrite & (aIdx == `SMSP_IDX_DATA);
	wire        wrCtrl  = aWr_q & (aIdx_q == `SMSP_IDX_CTRL);
	wire        wrStat  = aWr_q & (aIdx_q == `SMSP_IDX_STAT);
	wire        wrData  = aWr_q & (aIdx_q == `SMSP_IDX_DATA);
	wire        wrSel   = aWr_q & (aIdx_q == `SMSP_IDX_SEL);
	wire        busy    = mBusy | sBusy;
	wire        wrLoad  = wrData & ~busy;
	wire        dcClr   = armDc_q & (rdData | wrData);
	wire        mfClr   = armMf_q & wrCtrl;
	wire [7:0]  statVal;

	assign statVal = {done_q, write_collision_flag_q, 1'b0, mode_fault_flag_q, 1'b0, 1'b1, 1'b0, auto_q};

	// Sticky flag update; a set in the clearing cycle wins
	function flagNext;
		input q;
		input setEv;
		input clrEv;
		begin
			flagNext = setEv | (q & ~clrEv);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus responses and pins

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Clock driven only as master, idles at polarity level
	assign sckOut  = isMst ? sckLvl_q : clock_polarity_bit;
	assign sckOe   = isMst;
	assign mosiOut = outBit_q;
	assign mosiOe  = isMst;
	assign misoOut = outBit_q;
	assign misoOe  = slvSel;
	assign irq     = ctrl_q[`SMSP_C_IE] & (done_q | mode_fault_flag_q);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; stage 1 feeds only stage 2

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ss1_q     <= 1'b1;
			ss2_q     <= 1'b1;
			ssPrev_q  <= 1'b1;
			sck1_q    <= 1'b0;
			sck2_q    <= 1'b0;
			sckPrev_q <= 1'b0;
			mosi1_q   <= 1'b0;
			mosi2_q   <= 1'b0;
			miso1_q   <= 1'b0;
			miso2_q   <= 1'b0;
		end else begin
			ss1_q     <= ssInN;
			ss2_q     <= ss1_q;
			ssPrev_q  <= ss2_q;
			sck1_q    <= sckIn;
			sck2_q    <= sck1_q;
			sckPrev_q <= sck2_q;
			mosi1_q   <= mosiIn;
			mosi2_q   <= mosi1_q;
			miso1_q   <= misoIn;
			miso2_q   <= miso1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus address phase; reads are answered from a snapshot taken here

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aWr_q  <= 1'b0;
			aIdx_q <= 12'h000;
			hrdata <= 32'h0000_0000;
		end else begin
			aWr_q  <= aValid & hwrite;
			aIdx_q <= aIdx;
			if (aValid & ~hwrite) begin
				case (aIdx)
					`SMSP_IDX_CTRL: hrdata <= {24'h00_0000, ctrl_q};
					`SMSP_IDX_STAT: hrdata <= {24'h00_0000, statVal};
					`SMSP_IDX_DATA: hrdata <= {24'h00_0000, rxBuf_q};
					`SMSP_IDX_SEL:  hrdata <= {24'h00_0000, sel_q};
					default:        hrdata <= 32'h0000_0000;  // Unmapped reads zero
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers, flags and clear sequences

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q  <= `SMSP_CTRL_RST;
			sel_q   <= `SMSP_SEL_RST;
			auto_q  <= 1'b0;
			done_q  <= 1'b0;
			write_collision_flag_q  <= 1'b0;
			mode_fault_flag_q  <= 1'b0;
			armDc_q <= 1'b0;
			armMf_q <= 1'b0;
		end else begin
			// Control write; a fault in the same cycle still wins
			if (wrCtrl) begin
				ctrl_q <= hwdata[7:0];
			end
			if (fault) begin
				ctrl_q[`SMSP_C_MASTER_SELECT_BIT] <= 1'b0;
				ctrl_q[`SMSP_C_EN]   <= 1'b0;
			end
			if (wrSel) begin
				sel_q <= hwdata[7:0];
			end
			if (wrStat) begin
				auto_q <= hwdata[`SMSP_S_AUTO];
			end
			// Done from either side
			done_q <= flagNext(done_q, mDone | sDone, dcClr);
			write_collision_flag_q <= flagNext(write_collision_flag_q, wrData & busy, dcClr);
			// Only a master can fault
			mode_fault_flag_q <= flagNext(mode_fault_flag_q, fault, mfClr);
			// Arming: a status read opens each clear sequence
			if (rdStat) begin
				armDc_q <= 1'b1;
			end else if (dcClr) begin
				armDc_q <= 1'b0;
			end
			if (rdStat) begin
				armMf_q <= mode_fault_flag_q;
			end else if (mfClr) begin
				armMf_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bit-rate timer; free running so a start waits for its overflow

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			baud_q <= 10'h000;
		end else if (baudTick) begin
			baud_q <= 10'h000;
		end else begin
			baud_q <= baud_q + 10'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Master sequencer

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q   <= ST_IDLE;
			edgeCnt_q <= 5'h00;
			sckLvl_q  <= 1'b0;
		end else if (fault | ~isMst) begin
			// Fault or leaving master mode aborts the byte
			state_q   <= ST_IDLE;
			edgeCnt_q <= 5'h00;
			sckLvl_q  <= clock_polarity_bit;
		end else begin
			case (state_q)
				ST_IDLE: begin
					sckLvl_q <= clock_polarity_bit;
					if (wrLoad) begin
						state_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					edgeCnt_q <= 5'h00;
					if (baudTick) begin
						state_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (mEdge) begin
						sckLvl_q  <= ~sckLvl_q;
						edgeCnt_q <= edgeCnt_q + 5'h01;
					end
					if (mDone) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Slave bit counting; select high aborts and clears the count

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			slvCnt_q <= 4'h0;
			slvAct_q <= 1'b0;
		end else if (~slvSel) begin
			slvCnt_q <= 4'h0;
			slvAct_q <= 1'b0;
		end else if (sDone) begin
			slvCnt_q <= 4'h0;
			slvAct_q <= 1'b0;
		end else begin
			if (sEdge) begin
				slvAct_q <= 1'b1;
			end
			if (sSample) begin
				slvCnt_q <= slvCnt_q + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shifter: one bit in on the sample edge, one out on the other

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			shift_q  <= `SMSP_DATA_RST;
			outBit_q <= 1'b0;
			rxBuf_q  <= `SMSP_DATA_RST;
		end else if (wrLoad) begin
			// Only an idle port takes the byte
			shift_q  <= hwdata[7:0];
			outBit_q <= hwdata[7];
		end else if (mSample | sSample) begin
			shift_q <= {shift_q[6:0], isMst ? miso2_q : mosi2_q};
			if (sDone | mDone) begin
				rxBuf_q <= {shift_q[6:0], isMst ? miso2_q : mosi2_q};
			end
		end else if (mShiftO | sShiftO) begin
			outBit_q <= shift_q[7];
			if (mDone) begin
				rxBuf_q <= shift_q;
			end
		end else if (slvSel & ~ssPrev_q & ~slvAct_q) begin
			outBit_q <= shift_q[7];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Select outputs, eight lines, low selects

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ssOutN <= `SMSP_SEL_RST;
		end else if (auto_q & isMst) begin
			// Pattern only for the byte's duration
			ssOutN <= mBusy ? sel_q : `SMSP_SEL_RST;
		end else begin
			ssOutN <= sel_q;
		end
	end

endmodule // smsp_core
`default_nettype wire

// ==== verification/smsp_core_props.sv ====
// Purpose: Port-level checks of the serial port core
// Assumes: Zero-wait bus; serial inputs pass two sync flops
// Notes:   Bound to smsp_core at the foot of this file
`default_nettype none
module smsp_core_props (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	// Bus answer
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// Serial pins
	input wire logic        ssInN,
	input wire logic        sckOut,
	input wire logic        sckOe,
	input wire logic        mosiOe,
	input wire logic        misoOe,
	input wire logic [7:0]  ssOutN,
	input wire logic        irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// Select left inactive long enough to pass the sync flops
	sequence selIdle; ssInN [*4]; endsequence
	// Select pulled low by another master for a while
	sequence selTaken; !ssInN [*6]; endsequence
	////////////////////////////////////////////////////////////////
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not zero-wait okay");
	rst_values_a: assert property ($fell(sys_rst) |-> ssOutN == 8'hff && !irq && !sckOe)
		else $error("pins not at rest after reset");
	upper_zero_a: assert property (hrdata[31:8] == 24'h0)
		else $error("read data above byte not zero");
	master_pins_a: assert property (mosiOe == sckOe)
		else $error("master drivers disagree");
	drive_excl_a: assert property (misoOe |-> !sckOe)
		else $error("slave and master drivers both on");
	slave_quiet_a: assert property (selIdle |=> !misoOe)
		else $error("unselected slave drives data line");
	fault_drop_a: assert property (selTaken |-> !sckOe)
		else $error("master kept driving after fault");
	sck_spacing_a: assert property (sckOe && $changed(sckOut) |=> $stable(sckOut))
		else $error("serial clock faster than a quarter");
endmodule // smsp_core_props

bind smsp_core smsp_core_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ssInN(ssInN),
	.sckOut(sckOut), .sckOe(sckOe), .mosiOe(mosiOe), .misoOe(misoOe),
	.ssOutN(ssOutN), .irq(irq));
`default_nettype wire

// ==== verification/smsp_slave_model.sv ====
// Purpose: Behavioural far-end slave for master-mode transfers
// Assumes: Clock phase 0, polarity 0, select active low
// Notes:   A released data line shows the inverse of its last bit
`default_nettype none
module smsp_slave_model (
	// Serial bus from the master
	input  wire logic       sck,
	input  wire logic       selN,
	input  wire logic       mosi,
	// Byte to answer with and byte collected
	input  wire logic [7:0] txByte,
	output var  logic       miso,
	output var  logic [7:0] rxByte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] shiftQ; // Outgoing shifter
	initial miso = 1'b0;
	// Selection presents the first bit, as phase 0 has no edge before it
	always @(negedge selN) begin
		shiftQ = txByte;
		rxByte = 8'h00;
		miso   = txByte[7];
	end
	// Leading edge samples the master's bit
	always @(posedge sck) if (!selN) rxByte = {rxByte[6:0], mosi};
	// Trailing edge moves the next bit out
	always @(negedge sck) if (!selN) begin
		shiftQ = {shiftQ[6:0], 1'b0};
		miso   = shiftQ[7];
	end
	// A released line is not trusted to hold its level
	always @(posedge selN) miso = ~miso;
endmodule // smsp_slave_model
`default_nettype wire

// ==== verification/spi_master_slave_port_tb.sv ====
// Purpose: Self-checking bench for the serial port core
// Assumes: Zero-wait AHB-Lite slave at word addresses 0x3b0..0x3bc
// Notes:   Bench plays the external master in slave mode
`default_nettype none
module spi_master_slave_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] CTRL = 32'h3b0, STAT = 32'h3b4, DATA = 32'h3b8, SEL = 32'h3bc;
	localparam logic [7:0]  MB   = 8'h5a; // Byte sent by the bench as master
	// Bus and far-end drive
	logic        ref_clk, sys_rst, hsel, hwrite, sckTb, mosiTb, ssInN;
	logic [31:0] haddr, hwdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  slvTx;
	// Design outputs
	wire logic        hreadyout, hresp, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe;
	wire logic        irq, slvMiso;
	wire logic [31:0] hrdata;
	wire logic [7:0]  ssOutN, slvRx;
	// Each pin carries whichever party enables its driver
	wire logic sckPin  = sckOe ? sckOut : sckTb;
	wire logic mosiPin = mosiOe ? mosiOut : mosiTb;
	wire logic misoPin = misoOe ? misoOut : slvMiso;
	int errTotal = 0;
	int checked  = 0;
	smsp_core DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.sckIn(sckPin), .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiPin),
		.mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoPin), .misoOut(misoOut),
		.misoOe(misoOe), .ssInN(ssInN), .ssOutN(ssOutN), .irq(irq));
	smsp_slave_model u_slave (.sck(sckOut), .selN(ssOutN[0]), .mosi(mosiOut),
		.txByte(slvTx), .miso(slvMiso), .rxByte(slvRx));
	////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge ref_clk);
		errTotal++;
		summarize();
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errTotal++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One single word transfer; waits for hready in both phases
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		hsel <= 1'b0;
	endtask
	task automatic rc(input logic [31:0] a, input logic [31:0] exp, input string nm);
		bus(1'b0, a, 32'h0);
		chk(nm, rd, exp);
	endtask
	// Polls status until the done flag shows, bounded
	task automatic waitDone();
		int n;
		n = 0;
		do begin
			bus(1'b0, STAT, 32'h0);
			n++;
		end while (rd[7] !== 1'b1 && n < 200);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic regReset();
		rc(CTRL, 32'h04, "ctrl reset");
		rc(STAT, 32'h04, "status reset");
		rc(DATA, 32'h04, "data reset");
		rc(SEL, 32'hff, "select reset");
		rc(32'h3c0, 32'h0, "unmapped");
	endtask
	// Auto-select master byte with a colliding write mid-run
	task automatic masterXfer();
		slvTx = 8'h3c;
		bus(1'b1, SEL, 32'hfe);
		bus(1'b1, STAT, 32'h01);
		bus(1'b1, CTRL, 32'hd2);
		bus(1'b1, DATA, 32'ha5);
		repeat (10) @(posedge ref_clk);
		bus(1'b1, DATA, 32'h5a);
		chk("auto select busy", ssOutN, 8'hfe);
		chk("clock driven", sckOe, 1'b1);
		waitDone();
		chk("status done", rd, 32'hc5);
		chk("done irq", irq, 1'b1);
		chk("sent byte", slvRx, 8'ha5);
		chk("auto select idle", ssOutN, 8'hff);
		rc(DATA, 32'h3c, "received byte");
		rc(STAT, 32'h05, "flags cleared");
		chk("irq cleared", irq, 1'b0);
	endtask
	// Software select holds its pattern, idle and busy alike
	task automatic manualSelect();
		bus(1'b1, STAT, 32'h00);
		bus(1'b1, SEL, 32'ha5);
		bus(1'b1, DATA, 32'h81);
		repeat (20) @(posedge ref_clk);
		chk("manual select busy", ssOutN, 8'ha5);
		waitDone();
		bus(1'b0, DATA, 32'h0);
		chk("manual select idle", ssOutN, 8'ha5);
		bus(1'b1, SEL, 32'hff);
	endtask
	// Fastest rate, phase 1, polarity 1; far end unselected, so data in is flat
	task automatic masterIdleHigh();
		logic [7:0] flat;
		bus(1'b1, CTRL, 32'h5c);
		repeat (2) @(posedge ref_clk);
		chk("clock idles high", sckOut, 1'b1);
		flat = {8{misoPin}};
		bus(1'b1, DATA, 32'h3c);
		waitDone();
		chk("phase one done", rd, 32'h84);
		rc(DATA, {24'h0, flat}, "phase one received");
		chk("clock idles high after", sckOut, 1'b1);
		bus(1'b1, CTRL, 32'hd2);
	endtask
	// Another master takes the select line
	task automatic modeFault();
		ssInN <= 1'b0;
		repeat (8) @(posedge ref_clk);
		ssInN <= 1'b1;
		rc(STAT, 32'h14, "fault flag");
		rc(CTRL, 32'h82, "fault ctrl");
		chk("fault irq", irq, 1'b1);
		bus(1'b1, CTRL, 32'h44);
		rc(STAT, 32'h04, "fault cleared");
	endtask
	// Bench as external master, phase 1, then phase 0 collision
	task automatic slaveXfer();
		logic [7:0] got;
		bus(1'b1, DATA, 32'h96);
		ssInN <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			repeat (5) @(posedge ref_clk);
			sckTb  <= 1'b1;
			mosiTb <= MB[i];
			repeat (5) @(posedge ref_clk);
			got[i] = misoOut;
			sckTb <= 1'b0;
		end
		repeat (8) @(posedge ref_clk);
		chk("slave sent", got, 8'h96);
		chk("slave drives", misoOe, 1'b1);
		rc(STAT, 32'h84, "slave done");
		rc(DATA, {24'h0, MB}, "slave received");
		ssInN <= 1'b1;
		bus(1'b1, CTRL, 32'h40);
		ssInN <= 1'b0;
		repeat (4) @(posedge ref_clk);
		bus(1'b1, DATA, 32'h11);
		rc(STAT, 32'h44, "select low collides");
		ssInN <= 1'b1;
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checked, errTotal);
		if (errTotal == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		sys_rst = 1'b1;
		hsel    = 1'b0;
		haddr   = 32'h0;
		htrans  = 2'h0;
		hwrite  = 1'b0;
		hsize   = 3'h2;
		hwdata  = 32'h0;
		sckTb   = 1'b0;
		mosiTb  = 1'b0;
		ssInN   = 1'b1;
		slvTx   = 8'h00;
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		regReset();
		masterXfer();
		manualSelect();
		masterIdleHigh();
		modeFault();
		slaveXfer();
		summarize();
	end
endmodule // spi_master_slave_port_tb
`default_nettype wire
